// [verilog/bpp_port.sv]
/*
 * One 8-bit general purpose port: direction and output latch registers,
 * pin sampler, pull-up control, sleep input clamp, global pull-up disable
 * and a sticky edge interrupt per pin.
 * Assumes pad inputs synchronous-ish to clock, sleep level from the
 * sleep controller, and a register master that never waits.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module bpp_port (
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 clkEn,
    input  wire bpp_pkg::bpp_req_type req,
    output logic [7:0]                rdata,
    input  wire logic [7:0]           padIn,
    output bpp_pkg::bpp_pad_type      pad,
    input  wire logic                 sleepDeep,
    output logic                      irq
);
    logic [7:0] dirQ;
    logic [7:0] latchQ;
    logic [7:0] syncLatch;
    logic [7:0] sampledQ;
    logic [7:0] pudCtrlQ;
    logic [7:0] extEnQ;
    logic [7:0] statQ;
    logic [7:0] irqEnQ;
    logic [7:0] prevQ;
    logic [7:0] rdataQ;
    logic [7:0] clamped;
    logic [7:0] edgeHit;
    logic [1:0] primeCntQ;
    logic       primed;
    logic       global_pullup_disable;
    logic       wrDir;
    logic       wrLatch;
    logic       wrToggle;
    logic       wrCtrl;
    logic       wrClr;
    logic       wrIrqEn;
    logic       wrExtEn;

    assign global_pullup_disable      = pudCtrlQ[bpp_pkg::PUD_BIT];
    assign wrDir    = req.wr && clkEn && req.addr == bpp_pkg::ADDR_DIRECTION;
    assign wrLatch  = req.wr && clkEn && req.addr == bpp_pkg::ADDR_OUT_LATCH;
    assign wrToggle = req.wr && clkEn && req.addr == bpp_pkg::ADDR_SAMPLED;
    assign wrCtrl   = req.wr && clkEn && req.addr == bpp_pkg::ADDR_MCU_CTRL;
    assign wrClr    = req.wr && clkEn && req.addr == bpp_pkg::ADDR_IRQ_CLR;
    assign wrIrqEn  = req.wr && clkEn && req.addr == bpp_pkg::ADDR_IRQ_EN;
    assign wrExtEn  = req.wr && clkEn && req.addr == bpp_pkg::ADDR_EXT_EN;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dirQ <= bpp_pkg::RST_DIRECTION;
        end else if (wrDir) begin
            dirQ <= req.wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latchQ <= bpp_pkg::RST_OUT_LATCH;
        end else if (wrLatch) begin
            latchQ <= req.wdata;
        end else if (wrToggle) begin
            latchQ <= latchQ ^ req.wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pudCtrlQ <= bpp_pkg::RST_ZERO;
            extEnQ   <= bpp_pkg::RST_ZERO;
            irqEnQ   <= bpp_pkg::RST_ZERO;
        end else begin
            if (wrCtrl) begin
                pudCtrlQ <= req.wdata & (8'h01 << bpp_pkg::PUD_BIT);
            end
            if (wrExtEn) begin
                extEnQ <= req.wdata;
            end
            if (wrIrqEn) begin
                irqEnQ <= req.wdata;
            end
        end
    end

    // Pad drive and pull-up, combinational from the registers
    always_comb begin
        pad.pinOe    = dirQ;
        pad.pinOut   = latchQ & dirQ;
        pad.pullupEn = ~dirQ & latchQ & {8{~global_pullup_disable}};
    end

    // Deep sleep clamps inputs to ground unless the external interrupt is on
    assign clamped = padIn & ~({8{sleepDeep}} & ~extEnQ);

    // Latch open while clock is high, closed while low
    always_latch begin
        if (clock) begin
            syncLatch <= clamped;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sampledQ <= bpp_pkg::RST_ZERO;
        end else if (clkEn) begin
            sampledQ <= syncLatch;
        end
    end

    // Edges count only once the sampler and its delayed copy hold pad levels
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            primeCntQ <= 2'h0;
        end else if (clkEn && !primed) begin
            primeCntQ <= primeCntQ + 2'h1;
        end
    end

    assign primed = (primeCntQ == bpp_pkg::PRIME_EDGES);

    // Edge detect on the sampled level; the clamp release counts as a change
    assign edgeHit = (sampledQ ^ prevQ) & {8{primed}};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prevQ <= bpp_pkg::RST_ZERO;
        end else if (clkEn) begin
            prevQ <= sampledQ;
        end
    end

    // Set wins over clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            statQ <= bpp_pkg::RST_ZERO;
        end else if (clkEn) begin
            statQ <= (statQ & ~(wrClr ? req.wdata : 8'h00)) | edgeHit;
        end
    end

    assign irq = |(statQ & irqEnQ);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdataQ <= bpp_pkg::RST_ZERO;
        end else if (clkEn && req.rd) begin
            unique case (req.addr)
                bpp_pkg::ADDR_DIRECTION: rdataQ <= dirQ;
                bpp_pkg::ADDR_OUT_LATCH: rdataQ <= latchQ;
                bpp_pkg::ADDR_SAMPLED:   rdataQ <= sampledQ;
                bpp_pkg::ADDR_MCU_CTRL:  rdataQ <= pudCtrlQ;
                bpp_pkg::ADDR_IRQ_STAT:  rdataQ <= statQ;
                bpp_pkg::ADDR_IRQ_CLR:   rdataQ <= 8'h00;
                bpp_pkg::ADDR_IRQ_EN:    rdataQ <= irqEnQ;
                bpp_pkg::ADDR_EXT_EN:    rdataQ <= extEnQ;
            endcase
        end
    end

    assign rdata = rdataQ;

    // Pad control
    a_dir_drives: assert property (@(posedge clock) disable iff (!arst_n)
        pad.pinOe == dirQ
        && (pad.pinOut & ~dirQ) == 8'h00)
        else $error("pin enable differs from direction");

    a_dir_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrDir
        |=> dirQ == $past(req.wdata))
        else $error("direction write lost");

    a_dir_hold: assert property (@(posedge clock) disable iff (!arst_n)
        !wrDir
        |=> $stable(dirQ))
        else $error("direction changed without a write");

    a_pullup_rule: assert property (@(posedge clock) disable iff (!arst_n)
        pad.pullupEn
        == (~dirQ & latchQ & {8{~global_pullup_disable}}))
        else $error("pull-up enable wrong");

    a_pullup_on: assert property (@(posedge clock) disable iff (!arst_n)
        !global_pullup_disable
        |-> (pad.pullupEn & ~dirQ & latchQ) == (~dirQ & latchQ))
        else $error("pull-up missing on input with latch set");

    a_pullup_off: assert property (@(posedge clock) disable iff (!arst_n)
        (pad.pullupEn & (dirQ | ~latchQ))
        == 8'h00)
        else $error("pull-up on for output or zero latch");

    a_pud_global: assert property (@(posedge clock) disable iff (!arst_n)
        global_pullup_disable
        |-> pad.pullupEn == 8'h00)
        else $error("pull-up on while disabled");

    a_pud_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrCtrl
        |=> global_pullup_disable == $past(req.wdata[bpp_pkg::PUD_BIT]))
        else $error("pull-up disable write lost");

    a_ctrl_mask: assert property (@(posedge clock) disable iff (!arst_n)
        (pudCtrlQ & ~(8'h01 << bpp_pkg::PUD_BIT))
        == 8'h00)
        else $error("control register holds unused bits");

    a_out_level: assert property (@(posedge clock) disable iff (!arst_n)
        (pad.pinOut & dirQ)
        == (latchQ & dirQ))
        else $error("output level differs from latch");

    a_latch_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrLatch
        |=> latchQ == $past(req.wdata))
        else $error("latch write lost");

    // Reset
    a_reset_tristate: assert property (@(posedge clock)
        !arst_n
        |-> pad.pinOe == 8'h00 && pad.pullupEn == 8'h00)
        else $error("pin driven in reset");

    a_reset_release: assert property (@(posedge clock)
        $rose(arst_n)
        |-> pad.pinOe == 8'h00 && pad.pullupEn == 8'h00 && rdata == 8'h00 && !irq)
        else $error("outputs not idle after reset");

    // Latch toggling and register reads
    a_toggle_latch: assert property (@(posedge clock) disable iff (!arst_n)
        wrToggle
        |=> latchQ == ($past(latchQ) ^ $past(req.wdata)))
        else $error("toggle write wrong");

    a_toggle_zero: assert property (@(posedge clock) disable iff (!arst_n)
        wrToggle
        |=> (latchQ & ~$past(req.wdata)) == ($past(latchQ) & ~$past(req.wdata)))
        else $error("zero toggle bit changed the latch");

    a_latch_hold: assert property (@(posedge clock) disable iff (!arst_n)
        !wrLatch && !wrToggle
        |=> $stable(latchQ))
        else $error("latch changed without a write");

    a_read_dir: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && req.rd && req.addr == bpp_pkg::ADDR_DIRECTION
        |=> rdata == $past(dirQ))
        else $error("direction read wrong");

    a_read_latch: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && req.rd && req.addr == bpp_pkg::ADDR_OUT_LATCH
        |=> rdata == $past(latchQ))
        else $error("latch read wrong");

    a_read_sampled: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && req.rd && req.addr == bpp_pkg::ADDR_SAMPLED
        |=> rdata == $past(sampledQ))
        else $error("sampled level read wrong");

    a_read_stat: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && req.rd && req.addr == bpp_pkg::ADDR_IRQ_STAT
        |=> rdata == $past(statQ))
        else $error("status read wrong");

    a_read_clr: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && req.rd && req.addr == bpp_pkg::ADDR_IRQ_CLR
        |=> rdata == 8'h00)
        else $error("clear register reads nonzero");

    a_read_hold: assert property (@(posedge clock) disable iff (!arst_n)
        !(clkEn && req.rd)
        |=> $stable(rdata))
        else $error("read data moved without a read");

    // Input sampler and sleep clamp
    a_sample_path: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn
        |=> sampledQ == $past(syncLatch))
        else $error("sampler missed the latch value");

    a_sample_freeze: assert property (@(posedge clock) disable iff (!arst_n)
        !clkEn
        |=> $stable(sampledQ))
        else $error("sampler moved while frozen");

    a_pad_delay: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && !sleepDeep
        |=> sampledQ == $past(padIn))
        else $error("pad level late in sampler");

    sequence s_write_out;
        wrLatch && !sleepDeep;
    endsequence

    a_readback_delay: assert property (@(posedge clock) disable iff (!arst_n)
        s_write_out ##1 (clkEn && !sleepDeep && padIn == latchQ)
        |=> sampledQ == $past(latchQ))
        else $error("readback not seen one clock later");

    a_sleep_clamp: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && sleepDeep
        |=> (sampledQ & ~$past(extEnQ)) == 8'h00)
        else $error("clamped input reads high");

    a_clamp_exempt: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && sleepDeep
        |=> (sampledQ & $past(extEnQ)) == ($past(padIn) & $past(extEnQ)))
        else $error("exempt pin was clamped");

    a_ext_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrExtEn
        |=> extEnQ == $past(req.wdata))
        else $error("external enable write lost");

    // Interrupt flags
    sequence s_clamped;
        clkEn && sleepDeep;
    endsequence

    sequence s_awake;
        clkEn && !sleepDeep && primed;
    endsequence

    a_wake_flag: assert property (@(posedge clock) disable iff (!arst_n)
        s_clamped ##1 s_awake ##1 s_awake
        |=> (statQ & $past(padIn, 2) & ~$past(extEnQ, 3)) == ($past(padIn, 2) & ~$past(extEnQ, 3)))
        else $error("clamp release did not set flag");

    a_edge_sticky: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && edgeHit != 8'h00
        |=> (statQ & $past(edgeHit)) == $past(edgeHit))
        else $error("edge lost");

    a_stat_clear: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && wrClr && edgeHit == 8'h00
        |=> (statQ & $past(req.wdata)) == 8'h00)
        else $error("status clear ignored");

    a_stat_hold: assert property (@(posedge clock) disable iff (!arst_n)
        clkEn && !wrClr && edgeHit == 8'h00
        |=> $stable(statQ))
        else $error("status changed with no event");

    a_irqen_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrIrqEn
        |=> irqEnQ == $past(req.wdata))
        else $error("interrupt enable write lost");

    a_irq_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        irqEnQ == 8'h00
        |-> !irq)
        else $error("interrupt raised while all disabled");
endmodule : bpp_port

// [verilog/bpp_pkg.sv]
/*
 * Package for the bidirectional port pin block: port width, register
 * offsets, reset values and the packed carrier types.
 * Assumes one clock domain and a plain register port of 8-bit data.
 */
package bpp_pkg;
    localparam int unsigned PORT_WIDTH = 8;

    localparam logic [2:0] ADDR_DIRECTION = 3'h0;
    localparam logic [2:0] ADDR_OUT_LATCH = 3'h1;
    localparam logic [2:0] ADDR_SAMPLED   = 3'h2;
    localparam logic [2:0] ADDR_MCU_CTRL  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STAT  = 3'h4;
    localparam logic [2:0] ADDR_IRQ_CLR   = 3'h5;
    localparam logic [2:0] ADDR_IRQ_EN    = 3'h6;
    localparam logic [2:0] ADDR_EXT_EN    = 3'h7;

    localparam int unsigned PUD_BIT = 4;

    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OUT_LATCH = 8'h00;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [1:0] PRIME_EDGES   = 2'h2;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bpp_req_type;

    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOe;
        logic [7:0] pullupEn;
    } bpp_pad_type;
endpackage : bpp_pkg

// [verif/bpp_board.sv]
/*
 * Board model at the port pads.
 * Assumes a driven pin beats its pull-up, and a pull-up beats a weak external level.
 */
`timescale 1ns/1ps
module bpp_board (
    input  wire bpp_pkg::bpp_pad_type pad,
    input  wire logic [7:0]           ext,
    output logic [7:0]                padIn
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            padIn[i] = pad.pinOe[i] ? pad.pinOut[i] : (pad.pullupEn[i] | ext[i]);
        end
    end
endmodule : bpp_board

// [verif/tb_top.sv]
/*
 * Self-checking bench for bpp_port with the board model.
 * Assumes a 200 MHz clock and a register master that never waits.
 */
`timescale 1ns/1ps
module tb_top;
    logic                 clock;
    logic                 arst_n;
    logic                 clkEn;
    logic                 sleepDeep;
    logic                 irq;
    logic                 rdLate;
    logic                 global_pullup_disable;
    logic [7:0]           ext;
    logic [7:0]           padIn;
    logic [7:0]           rdata;
    logic [7:0]           lfsr;
    logic [7:0]           dir;
    logic [7:0]           lat;
    logic [7:0]           expQ[$];
    bpp_pkg::bpp_req_type req;
    bpp_pkg::bpp_pad_type pad;
    int                   failures = 0;
    int                   tests_run = 0;
    int                   cycles = 0;

    bpp_port u_bpp_port (.clock(clock), .arst_n(arst_n), .clkEn(clkEn), .req(req),
        .rdata(rdata), .padIn(padIn), .pad(pad), .sleepDeep(sleepDeep), .irq(irq));
    bpp_board u_bpp_board (.pad(pad), .ext(ext), .padIn(padIn));

    function automatic logic [7:0] nextRand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nextRand

    // Expected pin level: driven value, else pull-up or external level
    function automatic logic [7:0] sam(input logic [7:0] l);
        return (dir & l) | (~dir & ((l & {8{~global_pullup_disable}}) | ext));
    endfunction : sam

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask : bus

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expQ.push_back(e);
        bus(a, 8'h00, 1'b0);
    endtask : rd

    task automatic results;
        $display("Counts: tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Read data are checked in the cycle after the strobe; rdata then holds until the next read
    always @(posedge clock) rdLate <= req.rd & arst_n & clkEn;
    always @(negedge clock) begin
        if (rdLate) check(rdata, expQ.pop_front());
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            results();
        end
    end

    initial begin
        arst_n = 1'b0;
        clkEn = 1'b1;
        sleepDeep = 1'b0;
        ext = 8'h00;
        req = '0;
        lfsr = 8'h10;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rd(bpp_pkg::ADDR_DIRECTION, bpp_pkg::RST_DIRECTION);
        rd(bpp_pkg::ADDR_OUT_LATCH, bpp_pkg::RST_OUT_LATCH);
        for (int i = 0; i < 6; i++) begin
            lfsr = nextRand(lfsr);
            dir = lfsr;
            lfsr = nextRand(lfsr);
            lat = lfsr;
            global_pullup_disable = i[0];
            ext <= lfsr ^ dir;
            bus(bpp_pkg::ADDR_MCU_CTRL, 8'(global_pullup_disable) << bpp_pkg::PUD_BIT, 1'b1);
            bus(bpp_pkg::ADDR_OUT_LATCH, lat, 1'b1);
            bus(bpp_pkg::ADDR_DIRECTION, dir, 1'b1);
            @(negedge clock);
            check(pad.pinOe, dir);
            check(pad.pinOut & dir, lat & dir);
            check(pad.pullupEn, ~dir & lat & {8{~global_pullup_disable}});
            rd(bpp_pkg::ADDR_SAMPLED, sam(lat));
            bus(bpp_pkg::ADDR_SAMPLED, lfsr ^ 8'h3C, 1'b1);
            lat = lat ^ lfsr ^ 8'h3C;
            rd(bpp_pkg::ADDR_SAMPLED, sam(lat));
            rd(bpp_pkg::ADDR_OUT_LATCH, lat);
            rd(bpp_pkg::ADDR_DIRECTION, dir);
        end
        clkEn <= 1'b0;
        bus(bpp_pkg::ADDR_DIRECTION, ~dir, 1'b1);
        clkEn <= 1'b1;
        rd(bpp_pkg::ADDR_DIRECTION, dir);
        bus(bpp_pkg::ADDR_DIRECTION, 8'h00, 1'b1);
        bus(bpp_pkg::ADDR_OUT_LATCH, 8'h00, 1'b1);
        bus(bpp_pkg::ADDR_EXT_EN, 8'h0F, 1'b1);
        ext <= 8'hFF;
        sleepDeep <= 1'b1;
        repeat (3) @(posedge clock);
        rd(bpp_pkg::ADDR_SAMPLED, 8'h0F);
        bus(bpp_pkg::ADDR_IRQ_CLR, 8'hFF, 1'b1);
        bus(bpp_pkg::ADDR_IRQ_STAT, 8'hFF, 1'b1);
        bus(bpp_pkg::ADDR_IRQ_EN, 8'hFF, 1'b1);
        rd(bpp_pkg::ADDR_IRQ_STAT, 8'h00);
        rd(bpp_pkg::ADDR_IRQ_CLR, 8'h00);
        sleepDeep <= 1'b0;
        repeat (3) @(posedge clock);
        rd(bpp_pkg::ADDR_IRQ_STAT, 8'hF0);
        @(negedge clock);
        check({7'h00, irq}, 8'h01);
        bus(bpp_pkg::ADDR_IRQ_EN, 8'h00, 1'b1);
        @(negedge clock);
        check({7'h00, irq}, 8'h00);
        bus(bpp_pkg::ADDR_MCU_CTRL, 8'h00, 1'b1);
        bus(bpp_pkg::ADDR_DIRECTION, 8'hF0, 1'b1);
        bus(bpp_pkg::ADDR_OUT_LATCH, 8'hFF, 1'b1);
        @(negedge clock);
        check(pad.pullupEn, 8'h0F);
        @(posedge clock);
        arst_n <= 1'b0;
        #1;
        check(pad.pinOe, 8'h00);
        check(pad.pullupEn, 8'h00);
        results();
    end
endmodule : tb_top
